// >>> verilog/eag_pkg.sv
// package for the effective address generator: offsets, field positions,
// reset values, fsm codes and the carrier structs.
// assumes one clock domain and a word-wide core memory port.
package eag_pkg;

    localparam int unsigned WORD_W = 18;
    localparam int unsigned ADDR_W = 17;
    localparam int unsigned REG_AW = 4;

    // register offsets on the plain register port
    localparam logic [REG_AW-1:0] OFF_MODE = 4'h0;
    localparam logic [REG_AW-1:0] OFF_INDEX = 4'h4;
    localparam logic [REG_AW-1:0] OFF_STATUS = 4'h8;
    localparam logic [REG_AW-1:0] OFF_LAST_EA = 4'hC;

    // instruction bits, bit 0 is the lsb of the word
    localparam int unsigned IND_BIT = 13;
    localparam int unsigned IDX_BIT = 12;
    localparam int unsigned PAGE_FIELD_W = 12;
    localparam int unsigned BANK_FIELD_W = 13;
    localparam int unsigned PTR_W = 15;

    localparam logic [ADDR_W-1:0] AUTOINC_LO = 17'h00008;
    localparam logic [ADDR_W-1:0] AUTOINC_HI = 17'h0000F;

    localparam logic RST_BANK_MODE = 1'b0;
    localparam logic [WORD_W-1:0] RST_INDEX = 18'h00000;

    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_PTR_RD = 3'b010,
        S_AI_WR = 3'b100
    } fsm_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } mem_cmd_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [REG_AW-1:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        fsm_t fsm;
        logic bank_mode;
        logic [WORD_W-1:0] index_offset_register;
        logic [WORD_W-1:0] instr;
        logic [ADDR_W-1:0] pc;
        logic [WORD_W-1:0] ptr;
        mem_cmd_t mem;
        logic [ADDR_W-1:0] ea;
        logic ea_valid;
        logic [31:0] rdata;
        logic sw_meta;
        logic sw_sync;
    } eag_state_t;

    localparam eag_state_t ST_RESET = '{
        fsm: S_IDLE,
        bank_mode: RST_BANK_MODE,
        index_offset_register: RST_INDEX,
        default: '0
    };

endpackage : eag_pkg

// >>> verilog/effective_address_generator.sv
// effective operand address generator for memory-reference instructions.
// assumes a sequencer that offers instructions with a pc, and a core memory
// that acknowledges each request with a one-cycle ack.
`timescale 1ns/10ps
module effective_address_generator (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input eag_pkg::reg_req_t reg_req_i,
    output logic [31:0] reg_rdata_o,
    input wire logic console_bank_sw_i,
    input wire logic prog_start_i,
    input wire logic [eag_pkg::ADDR_W-1:0] pc_i,
    input wire logic req_valid_i,
    input wire logic [eag_pkg::WORD_W-1:0] instr_i,
    output logic ready_o,
    output eag_pkg::mem_cmd_t mem_cmd_o,
    input wire logic mem_ack_i,
    input wire logic [eag_pkg::WORD_W-1:0] mem_rdata_i,
    output logic ea_valid_o,
    output logic [eag_pkg::ADDR_W-1:0] effective_operand_address_o
);

    eag_pkg::eag_state_t s;
    eag_pkg::eag_state_t next_s;

    // direct address: upper bits from pc, field width from mode
    function automatic logic [16:0] dir_addr(input logic [17:0] ins,
                                             input logic [16:0] pc,
                                             input logic bank);
        if (bank)
            return {pc[16:13], ins[12:0]};
        else
            return {pc[16:12], ins[11:0]};
    endfunction : dir_addr

    // address field seen as an absolute word number
    function automatic logic [16:0] field_abs(input logic [17:0] ins,
                                              input logic bank);
        if (bank)
            return {4'h0, ins[12:0]};
        else
            return {5'h00, ins[11:0]};
    endfunction : field_abs

    function automatic logic ai_hit(input logic [17:0] ins,
                                    input logic bank);
        logic [16:0] f;
        f = field_abs(ins, bank);
        return ins[eag_pkg::IND_BIT] && f >= eag_pkg::AUTOINC_LO
               && f <= eag_pkg::AUTOINC_HI;
    endfunction : ai_hit

    // index added last, full 18-bit signed sum cut to 17 bits
    function automatic logic [16:0] post_idx(input logic [16:0] base,
                                             input logic [17:0] ins,
                                             input logic bank,
                                             input logic [17:0] xr);
        logic [17:0] sum;
        sum = {1'b0, base} + xr;
        if (!bank && ins[eag_pkg::IDX_BIT])
            return sum[16:0];
        else
            return base;
    endfunction : post_idx

    logic accept;
    logic [17:0] incr_word;
    logic [16:0] ptr_base;

    assign accept = req_valid_i && (s.fsm == eag_pkg::S_IDLE);
    assign incr_word = mem_rdata_i + 18'h00001;
    // pointer keeps the current block, bits 0..14 come from memory
    assign ptr_base = {s.pc[16:15], mem_rdata_i[eag_pkg::PTR_W-1:0]};

    always_comb
    begin
        next_s = s;
        next_s.ea_valid = 1'b0;
        next_s.rdata = 32'h00000000;
        next_s.sw_meta = console_bank_sw_i;
        next_s.sw_sync = s.sw_meta;
        // switch sampled at program start, a later software write overrides
        if (prog_start_i)
            next_s.bank_mode = s.sw_sync;
        if (reg_req_i.wr)
        begin
            unique case (reg_req_i.addr)
                eag_pkg::OFF_MODE: next_s.bank_mode = reg_req_i.wdata[0];
                eag_pkg::OFF_INDEX:
                    next_s.index_offset_register = reg_req_i.wdata[17:0];
                default: ;
            endcase
        end
        if (reg_req_i.rd)
        begin
            unique case (reg_req_i.addr)
                eag_pkg::OFF_MODE: next_s.rdata = {31'h0, s.bank_mode};
                eag_pkg::OFF_INDEX:
                    next_s.rdata = {14'h0, s.index_offset_register};
                eag_pkg::OFF_STATUS: next_s.rdata = {29'h0, s.fsm};
                eag_pkg::OFF_LAST_EA: next_s.rdata = {15'h0, s.ea};
                default: next_s.rdata = 32'h00000000;
            endcase
        end
        unique case (s.fsm)
            eag_pkg::S_IDLE:
            begin
                if (accept)
                begin
                    next_s.instr = instr_i;
                    next_s.pc = pc_i;
                    if (instr_i[eag_pkg::IND_BIT])
                    begin
                        next_s.fsm = eag_pkg::S_PTR_RD;
                        next_s.mem.req = 1'b1;
                        next_s.mem.we = 1'b0;
                        // auto-increment words live in block 0 whatever the pc
                        if (ai_hit(instr_i, s.bank_mode))
                            next_s.mem.addr = field_abs(instr_i,
                                                        s.bank_mode);
                        else
                            next_s.mem.addr = dir_addr(instr_i, pc_i,
                                                       s.bank_mode);
                    end
                    else
                    begin
                        // no memory cycle, the sum is ready at once
                        next_s.ea = post_idx(dir_addr(instr_i, pc_i,
                                             s.bank_mode), instr_i,
                                             s.bank_mode,
                                             s.index_offset_register);
                        next_s.ea_valid = 1'b1;
                    end
                end
            end
            eag_pkg::S_PTR_RD:
            begin
                if (mem_ack_i)
                begin
                    if (ai_hit(s.instr, s.bank_mode))
                    begin
                        next_s.ptr = incr_word;
                        next_s.mem.we = 1'b1;
                        next_s.mem.wdata = incr_word;
                        next_s.fsm = eag_pkg::S_AI_WR;
                    end
                    else
                    begin
                        next_s.mem.req = 1'b0;
                        next_s.ea = post_idx(ptr_base, s.instr, s.bank_mode,
                                             s.index_offset_register);
                        next_s.ea_valid = 1'b1;
                        next_s.fsm = eag_pkg::S_IDLE;
                    end
                end
            end
            eag_pkg::S_AI_WR:
            begin
                // operand address held back until the write-back is taken
                if (mem_ack_i)
                begin
                    next_s.mem.req = 1'b0;
                    next_s.mem.we = 1'b0;
                    next_s.ea = post_idx(s.ptr[16:0], s.instr, s.bank_mode,
                                         s.index_offset_register);
                    next_s.ea_valid = 1'b1;
                    next_s.fsm = eag_pkg::S_IDLE;
                end
            end
            default: next_s.fsm = eag_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s <= eag_pkg::ST_RESET;
        else
            s <= next_s;
    end

    assign reg_rdata_o = s.rdata;
    assign ready_o = (s.fsm == eag_pkg::S_IDLE);
    assign mem_cmd_o = s.mem;
    assign ea_valid_o = s.ea_valid;
    assign effective_operand_address_o = s.ea;

    // checks
    logic [17:0] chk_idx_sum;
    logic [17:0] chk_post_sum;
    assign chk_idx_sum = {1'b0, pc_i[16:12], instr_i[11:0]}
                         + s.index_offset_register;
    assign chk_post_sum = {1'b0, ptr_base} + s.index_offset_register;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_bank_direct;
        accept && s.bank_mode && !instr_i[13] |=> ea_valid_o
        && effective_operand_address_o == {$past(pc_i[16:13]),
                                           $past(instr_i[12:0])};
    endproperty
    a_bank_direct: assert property (p_bank_direct)
        else $error("bank direct address wrong");

    property p_page_direct;
        accept && !s.bank_mode && !instr_i[13] && !instr_i[12] |=>
        effective_operand_address_o == {$past(pc_i[16:12]),
                                        $past(instr_i[11:0])};
    endproperty
    a_page_direct: assert property (p_page_direct)
        else $error("page direct address wrong");

    property p_index_sum;
        accept && !s.bank_mode && !instr_i[13] && instr_i[12] |=>
        ea_valid_o && !mem_cmd_o.req
        && effective_operand_address_o == $past(chk_idx_sum[16:0]);
    endproperty
    a_index_sum: assert property (p_index_sum)
        else $error("indexed sum wrong or late");

    property p_ind_read;
        accept && instr_i[13] |=> mem_cmd_o.req && !mem_cmd_o.we
        && !ea_valid_o;
    endproperty
    a_ind_read: assert property (p_ind_read)
        else $error("indirect pointer read not issued");

    // a request taken while ea_valid_o stands may legally start a read
    property p_direct_no_mem;
        accept && !instr_i[13] |=> !mem_cmd_o.req
        ##1 (!mem_cmd_o.req || $past(accept));
    endproperty
    a_direct_no_mem: assert property (p_direct_no_mem)
        else $error("direct reference touched memory");

    property p_ai_addr;
        accept && ai_hit(instr_i, s.bank_mode) |=>
        mem_cmd_o.addr == $past(field_abs(instr_i, s.bank_mode));
    endproperty
    a_ai_addr: assert property (p_ai_addr)
        else $error("auto-increment word not in block 0");

    property p_ai_writeback;
        s.fsm == eag_pkg::S_PTR_RD && mem_ack_i && ai_hit(s.instr,
        s.bank_mode) |=> mem_cmd_o.req && mem_cmd_o.we && !ea_valid_o
        && mem_cmd_o.wdata == $past(mem_rdata_i) + 18'h00001;
    endproperty
    a_ai_writeback: assert property (p_ai_writeback)
        else $error("auto-increment write-back wrong");

    property p_post_index;
        s.fsm == eag_pkg::S_PTR_RD && mem_ack_i && !ai_hit(s.instr,
        s.bank_mode) && !s.bank_mode && s.instr[12] |=> ea_valid_o
        && effective_operand_address_o == $past(chk_post_sum[16:0]);
    endproperty
    a_post_index: assert property (p_post_index)
        else $error("post-index sum wrong");

    property p_mode_start;
        prog_start_i && !reg_req_i.wr |=> s.bank_mode == $past(s.sw_sync);
    endproperty
    a_mode_start: assert property (p_mode_start)
        else $error("mode not taken from console switch");

    property p_ai_index;
        s.fsm == eag_pkg::S_AI_WR && mem_ack_i && !s.bank_mode
        && s.instr[12] |=> ea_valid_o && !mem_cmd_o.req
        && effective_operand_address_o
        == $past(s.ptr[16:0] + s.index_offset_register[16:0]);
    endproperty
    a_ai_index: assert property (p_ai_index)
        else $error("auto-increment indexed address wrong");

    property p_ai_bank;
        s.fsm == eag_pkg::S_AI_WR && mem_ack_i && s.bank_mode |=>
        ea_valid_o && effective_operand_address_o == $past(s.ptr[16:0]);
    endproperty
    a_ai_bank: assert property (p_ai_bank)
        else $error("bank mode auto-increment address wrong");

endmodule : effective_address_generator

// >>> tb/core_mem_model.sv
// core memory model: answers each request after the dly_i idle cycles loaded at the previous ack, 0 for the first after reset.
// assumes the requester holds its command until the cycle after ack.
`timescale 1ns/10ps
module core_mem_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input eag_pkg::mem_cmd_t cmd_i,
    input wire logic [3:0] dly_i,
    output logic ack_o,
    output logic [17:0] rdata_o
);
    logic [17:0] mem [0:131071];
    logic [3:0] wait_cnt;
    always @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ack_o <= 1'b0;
            wait_cnt <= 4'h0;
            rdata_o <= 18'h2AAAA;
        end
        else if (ack_o)
        begin
            ack_o <= 1'b0;
            wait_cnt <= dly_i;
            // no stale word after the ack cycle
            rdata_o <= ~rdata_o;
        end
        else if (cmd_i.req && wait_cnt != 4'h0)
            wait_cnt <= wait_cnt - 4'h1;
        else if (cmd_i.req)
        begin
            ack_o <= 1'b1;
            if (cmd_i.we)
                mem[cmd_i.addr] <= cmd_i.wdata;
            else
                rdata_o <= mem[cmd_i.addr];
        end
    end
endmodule : core_mem_model

// >>> tb/tb.sv
// self-checking bench for the effective address generator.
// assumes the core memory model stands behind the memory port.
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    fails++; \
    $display("mismatch t=%0t got %h exp %h", $time, a, b); \
    end end
module tb;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    eag_pkg::reg_req_t rq = '0;
    logic sw = 1'b0, start = 1'b0, req_valid = 1'b0;
    logic [16:0] pc = '0;
    logic [17:0] instr = '0;
    logic [3:0] dly = '0;
    logic [31:0] rdata, rv, r2, r3;
    logic ready, ack, ea_valid;
    eag_pkg::mem_cmd_t cmd;
    logic [17:0] mrd, ins;
    logic [16:0] ea_o, last_ea;
    int fails = 0, check_count = 0, seed = 17;
    logic [3:0] offs [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
    logic [31:0] rst_vals [5] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0};

    always #2 mclk_i = ~mclk_i;

    effective_address_generator i_effective_address_generator (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_req_i(rq),
        .reg_rdata_o(rdata), .console_bank_sw_i(sw), .prog_start_i(start),
        .pc_i(pc), .req_valid_i(req_valid), .instr_i(instr),
        .ready_o(ready), .mem_cmd_o(cmd), .mem_ack_i(ack),
        .mem_rdata_i(mrd), .ea_valid_o(ea_valid),
        .effective_operand_address_o(ea_o)
    );
    core_mem_model i_mem (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cmd_i(cmd), .dly_i(dly),
        .ack_o(ack), .rdata_o(mrd)
    );

    task reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        rq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk_i) rq.wr <= 1'b0;
    endtask : reg_wr

    task reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        rq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk_i) rq.rd <= 1'b0;
        @(negedge mclk_i);
        `CHK(rdata, e)
    endtask : reg_rd

    task automatic run_op(input logic [17:0] i, input logic [16:0] p,
        input logic [17:0] xr, input logic bank, input logic [17:0] d);
        logic [16:0] loc, ea;
        logic [17:0] dp;
        logic [31:0] r;
        logic ind, ai;
        int f, acks, cyc;
        ind = i[13];
        f = bank ? int'(i[12:0]) : int'(i[11:0]);
        ai = ind && f >= 8 && f <= 15;
        dp = d + 18'h00001;
        loc = bank ? {p[16:13], i[12:0]} : {p[16:12], i[11:0]};
        if (ai)
            loc = 17'(f);
        ea = loc;
        if (ind)
            ea = ai ? dp[16:0] : {p[16:15], d[14:0]};
        if (i[12] && !bank)
            ea = ea + xr[16:0];
        reg_wr(eag_pkg::OFF_INDEX, {14'h0, xr});
        reg_wr(eag_pkg::OFF_MODE, {31'h0, bank});
        i_mem.mem[loc] = d;
        r = $random(seed);
        @(posedge mclk_i);
        req_valid <= 1'b1;
        instr <= i;
        pc <= p;
        dly <= {2'h0, r[1:0]};
        @(posedge mclk_i) req_valid <= 1'b0;
        acks = 0;
        cyc = 0;
        do
        begin
            @(negedge mclk_i);
            cyc++;
            if (ack === 1'b1)
                acks++;
            if (cyc == 1)
                `CHK(ready, ~ind)
        end
        while (ea_valid !== 1'b1 && cyc < 100);
        `CHK(ea_valid, 1'b1)
        `CHK(acks, ai ? 2 : int'(ind))
        if (!ind)
            `CHK(cyc, 1)
        `CHK(ea_o, ea)
        `CHK(i_mem.mem[loc], ai ? dp : d)
        last_ea = ea;
    endtask : run_op

    task wrap_up;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // run is about 800 cycles; allow plenty
    initial
    begin
        #80000;
        fails++;
        wrap_up();
    end

    initial
    begin
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        reg_wr(4'h2, 32'h0000FFFF);
        reg_wr(eag_pkg::OFF_STATUS, 32'h00000007);
        foreach (offs[k])
            reg_rd(offs[k], rst_vals[k]);
        rv = $random(seed);
        reg_wr(eag_pkg::OFF_INDEX, rv);
        reg_rd(eag_pkg::OFF_INDEX, {14'h0, rv[17:0]});
        $display("test registers done");
        @(posedge mclk_i) sw <= 1'b1;
        repeat (3) @(posedge mclk_i);
        start <= 1'b1;
        @(posedge mclk_i) start <= 1'b0;
        reg_rd(eag_pkg::OFF_MODE, 32'h1);
        @(posedge mclk_i) sw <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rq <= '{wr: 1'b1, rd: 1'b0, addr: eag_pkg::OFF_MODE, wdata: 32'h1};
        start <= 1'b1;
        @(posedge mclk_i) rq.wr <= 1'b0;
        start <= 1'b0;
        reg_rd(eag_pkg::OFF_MODE, 32'h1);
        @(posedge mclk_i) start <= 1'b1;
        @(posedge mclk_i) start <= 1'b0;
        reg_rd(eag_pkg::OFF_MODE, 32'h0);
        $display("test mode_select done");
        run_op(18'h07040, 17'h10600, 18'h00040, 1'b0, 18'h00E00);
        `CHK(ea_o, 17'h10E40)
        run_op(18'h0700D, 17'h0F0A5, 18'h00200, 1'b0, 18'h001FF);
        `CHK(ea_o, 17'h00400)
        run_op(18'h01080, 17'h11600, 18'h2F180, 1'b0, 18'h00000);
        `CHK(ea_o, 17'h00200)
        run_op(18'h0000C, 17'h04000, 18'h00100, 1'b1, 18'h00123);
        `CHK(ea_o, 17'h0400C)
        $display("test directed done");
        repeat (80)
        begin
            rv = $random(seed);
            r2 = $random(seed);
            r3 = $random(seed);
            ins = r2[17:0];
            // bias towards the pointer words, rare otherwise
            if (rv[1:0] == 2'b00)
            begin
                ins[13] = 1'b1;
                ins[11:0] = {9'h001, rv[4:2]};
                ins[12] = ins[12] & ~rv[5];
            end
            run_op(ins, r3[16:0], {r3[31:17], rv[8:6]}, rv[5], rv[31:14]);
        end
        reg_rd(eag_pkg::OFF_LAST_EA, {15'h0, last_ea});
        $display("test random done");
        wrap_up();
    end
endmodule : tb
